//--- hw/tw_top.v
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Two independent controllers, each with registers.
// - Bits, clocking, addressing, arbitration done in hardware.
// - Master/slave transmit/receive, whole byte autonomously.
// - Rate code from control bits 7, 1, 0.
// - Bus clock is oscillator divided 16/14/40/60/120.
// - Enable bit 6 cleared releases both lines.
// - Begin request issues start or repeated start.
// - End request makes stop; cleared on stop seen.
// - Address-received bit set by hardware, software clears.
// - Ack enabled drives data low on ack.
// - Ack disabled leaves data high on ack.
// - Status register read-only, usable as vector.
// - Status 7 general call, 6 stop seen as slave.
// - Status 5 shows pending interrupt request.
// - Status 4 shows transmitter role.
// - Status 3 shows bus held by other master.
// - Status 2 shows lost arbitration.
// - Status 1 shows not-acknowledge received.
// - Status 0 shows slave role.
// - Eight-bit shift register, most significant first.
// - Own address in bits 7..1 selects slave.
// - Released lines free for port use.
// - Master on nack generates stop, goes idle.
// - Slave transmitter on nack releases, goes idle.
`include "tw_defs.vh"

module tw_engine (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       wr_ctl,
	input  wire       wr_dat,
	input  wire       wr_adr,
	input  wire [7:0] wdata,
	output wire [7:0] ctl_rd,
	output wire [7:0] sta_rd,
	output wire [7:0] dat_rd,
	output wire [7:0] adr_rd,
	input  wire       scl_i,
	input  wire       sda_i,
	output reg        scl_oe_n_q,
	output reg        sda_oe_n_q
);
	localparam [3:0] ST_IDLE  = 4'd0;
	localparam [3:0] ST_MSTA  = 4'd1;
	localparam [3:0] ST_MBYTE = 4'd2;
	localparam [3:0] ST_WAIT  = 4'd3;
	localparam [3:0] ST_MRS1  = 4'd4;
	localparam [3:0] ST_MRS2  = 4'd5;
	localparam [3:0] ST_MP1   = 4'd6;
	localparam [3:0] ST_MP2   = 4'd7;
	localparam [3:0] ST_SBYTE = 4'd8;

	reg [7:0] ctl_q;
	reg [7:0] dat_q;
	reg [7:0] adr_q;
	reg [3:0] state_q;
	reg [6:0] cnt_q;
	reg [3:0] bitcnt_q;
	reg       ph_q;
	reg       tx_q;
	reg       master_q;
	reg       slave_q;
	reg       addr_ph_q;
	reg       nack_q;
	reg       lost_q;
	reg       gc_q;
	reg       stop_q;
	reg       irq_q;
	reg       busy_q;
	reg       start_pend_q;
	reg       scl_s1_q;
	reg       scl_s2_q;
	reg       scl_s3_q;
	reg       sda_s1_q;
	reg       sda_s2_q;
	reg       sda_s3_q;
	reg [7:0] div;

	wire [2:0] rate    = {ctl_q[`TW_CTL_RATE_HIGH], ctl_q[`TW_CTL_RATE_MID],
		ctl_q[`TW_CTL_RATE_LOW]};
	wire [6:0] half_m1 = div[7:1] - 7'd1;
	wire       ack_en  = ctl_q[`TW_CTL_ACK_EN];
	wire       bus_on  = ctl_q[`TW_CTL_BUS_ON];
	wire       scl_rise  = scl_s2_q & ~scl_s3_q;
	wire       scl_fall  = ~scl_s2_q & scl_s3_q;
	wire       start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	wire       stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
	wire       in_byte   = (state_q == ST_MBYTE) || (state_q == ST_SBYTE);
	wire       id_match  = (dat_q[7:1] == adr_q[7:1]);
	wire       gc_match  = (dat_q[7:1] == 7'h00);
	wire       half_done = (cnt_q == half_m1);

	// Divisor table; unused codes fall to the slowest rate to stay safe.
	always @* begin
		case (rate)
		3'd0: div = `TW_DIV_R0;
		3'd1: div = `TW_DIV_R1;
		3'd2: div = `TW_DIV_R2;
		3'd3: div = `TW_DIV_R3;
		default: div = `TW_DIV_R4;
		endcase
	end

	// Status is assembled live from flags so software can branch on it.
	assign sta_rd = {gc_q, stop_q, irq_q, tx_q, busy_q & ~master_q,
		lost_q, nack_q, slave_q};
	assign ctl_rd = ctl_q;
	assign dat_rd = dat_q;
	assign adr_rd = {adr_q[7:1], 1'b0};

	// Both lines pass two flip-flops; the third stage only serves edge detection.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	// Main engine. Software writes come first so hardware sets below win.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q        <= `TW_CTL_RESET;
			dat_q        <= `TW_DAT_RESET;
			adr_q        <= `TW_ADR_RESET;
			state_q      <= ST_IDLE;
			cnt_q        <= 7'd0;
			bitcnt_q     <= 4'd0;
			ph_q         <= 1'b0;
			tx_q         <= 1'b0;
			master_q     <= 1'b0;
			slave_q      <= 1'b0;
			addr_ph_q    <= 1'b0;
			nack_q       <= 1'b0;
			lost_q       <= 1'b0;
			gc_q         <= 1'b0;
			stop_q       <= 1'b0;
			irq_q        <= 1'b0;
			busy_q       <= 1'b0;
			start_pend_q <= 1'b0;
			scl_oe_n_q   <= 1'b1;
			sda_oe_n_q   <= 1'b1;
		end else begin
			if (wr_ctl) begin
				ctl_q        <= wdata;
				start_pend_q <= wdata[`TW_CTL_BEGIN];
			end
			if (wr_adr)
				adr_q <= wdata;
			if (wr_dat) begin
				dat_q <= wdata;
				irq_q <= 1'b0;
			end

			// Bus occupancy is tracked even while disabled.
			if (start_det) begin
				busy_q <= 1'b1;
				gc_q   <= 1'b0;
				stop_q <= 1'b0;
			end
			if (stop_det) begin
				busy_q <= 1'b0;
				ctl_q[`TW_CTL_END] <= 1'b0;
				if (slave_q) begin
					stop_q <= 1'b1;
					irq_q  <= 1'b1;
				end
			end

			if (!bus_on) begin
				state_q    <= ST_IDLE;
				master_q   <= 1'b0;
				slave_q    <= 1'b0;
				tx_q       <= 1'b0;
				scl_oe_n_q <= 1'b1;
				sda_oe_n_q <= 1'b1;
			end else if (start_det && !master_q) begin
				// Any start from another master opens an address byte.
				state_q    <= ST_SBYTE;
				addr_ph_q  <= 1'b1;
				slave_q    <= 1'b0;
				tx_q       <= 1'b0;
				bitcnt_q   <= 4'd0;
				scl_oe_n_q <= 1'b1;
				sda_oe_n_q <= 1'b1;
			end else if (stop_det && !master_q) begin
				state_q    <= ST_IDLE;
				slave_q    <= 1'b0;
				tx_q       <= 1'b0;
				scl_oe_n_q <= 1'b1;
				sda_oe_n_q <= 1'b1;
			end else begin
				case (state_q)
				ST_IDLE: begin
					if (start_pend_q && !busy_q) begin
						state_q      <= ST_MSTA;
						start_pend_q <= 1'b0;
						master_q     <= 1'b1;
						addr_ph_q    <= 1'b1;
						tx_q         <= 1'b1;
						lost_q       <= 1'b0;
						sda_oe_n_q   <= 1'b0;
						cnt_q        <= 7'd0;
					end
				end
				ST_MSTA: begin
					if (half_done) begin
						scl_oe_n_q <= 1'b0;
						state_q    <= ST_MBYTE;
						ph_q       <= 1'b0;
						cnt_q      <= 7'd0;
						bitcnt_q   <= 4'd0;
					end else
						cnt_q <= cnt_q + 7'd1;
				end
				ST_MRS1: begin
					if (half_done) begin
						scl_oe_n_q <= 1'b1;
						state_q    <= ST_MRS2;
						cnt_q      <= 7'd0;
					end else
						cnt_q <= cnt_q + 7'd1;
				end
				ST_MRS2: begin
					if (scl_s2_q) begin
						if (half_done) begin
							sda_oe_n_q <= 1'b0;
							lost_q     <= 1'b0;
							state_q    <= ST_MSTA;
							cnt_q      <= 7'd0;
						end else
							cnt_q <= cnt_q + 7'd1;
					end
				end
				ST_MP1: begin
					if (half_done) begin
						scl_oe_n_q <= 1'b1;
						state_q    <= ST_MP2;
						cnt_q      <= 7'd0;
					end else
						cnt_q <= cnt_q + 7'd1;
				end
				ST_MP2: begin
					if (scl_s2_q) begin
						if (half_done) begin
							sda_oe_n_q <= 1'b1;
							master_q   <= 1'b0;
							tx_q       <= 1'b0;
							state_q    <= ST_IDLE;
						end else
							cnt_q <= cnt_q + 7'd1;
					end
				end
				ST_WAIT: begin
					// Clock stays low until software writes the data register.
					if (wr_dat) begin
						bitcnt_q <= 4'd0;
						cnt_q    <= 7'd0;
						ph_q     <= 1'b0;
						if (master_q && ctl_q[`TW_CTL_BEGIN]) begin
							state_q    <= ST_MRS1;
							addr_ph_q  <= 1'b1;
							tx_q       <= 1'b1;
							sda_oe_n_q <= 1'b1;
						end else if (master_q && ctl_q[`TW_CTL_END]) begin
							state_q    <= ST_MP1;
							sda_oe_n_q <= 1'b0;
						end else begin
							state_q    <= master_q ? ST_MBYTE : ST_SBYTE;
							sda_oe_n_q <= tx_q ? wdata[7] : 1'b1;
							if (!master_q)
								scl_oe_n_q <= 1'b1;
						end
					end
				end
				ST_MBYTE, ST_SBYTE: begin
				end
				default: state_q <= ST_IDLE;
				endcase

				// Master clock: low half driven, high half counted only
				// once the line is really high, so slow targets may stretch.
				if (state_q == ST_MBYTE) begin
					if (!ph_q) begin
						if (half_done) begin
							scl_oe_n_q <= 1'b1;
							ph_q       <= 1'b1;
							cnt_q      <= 7'd0;
						end else
							cnt_q <= cnt_q + 7'd1;
					end else if (scl_s2_q) begin
						if (half_done) begin
							scl_oe_n_q <= 1'b0;
							ph_q       <= 1'b0;
							cnt_q      <= 7'd0;
						end else
							cnt_q <= cnt_q + 7'd1;
					end
				end

				// Bit engine shared by all four roles.
				if (in_byte && scl_rise) begin
					if (bitcnt_q < 4'd8) begin
						dat_q <= {dat_q[6:0], sda_s2_q};
						if (master_q && tx_q && sda_oe_n_q && !sda_s2_q) begin
							state_q    <= ST_IDLE;
							master_q   <= 1'b0;
							tx_q       <= 1'b0;
							lost_q     <= 1'b1;
							irq_q      <= 1'b1;
							scl_oe_n_q <= 1'b1;
							sda_oe_n_q <= 1'b1;
						end
					end else if (bitcnt_q == 4'd8 && tx_q)
						nack_q <= sda_s2_q;
					bitcnt_q <= bitcnt_q + 4'd1;
				end
				if (in_byte && scl_fall) begin
					if (bitcnt_q < 4'd8) begin
						if (tx_q)
							sda_oe_n_q <= dat_q[7];
					end else if (bitcnt_q == 4'd8) begin
						if (tx_q)
							sda_oe_n_q <= 1'b1;
						else if (addr_ph_q && !master_q) begin
							if ((id_match || gc_match) && ack_en)
								sda_oe_n_q <= 1'b0;
							else begin
								sda_oe_n_q <= 1'b1;
								state_q    <= ST_IDLE;
							end
						end else
							sda_oe_n_q <= ~ack_en;
					end else begin
						sda_oe_n_q <= 1'b1;
						addr_ph_q  <= 1'b0;
						irq_q      <= 1'b1;
						if (master_q) begin
							if (tx_q && nack_q) begin
								state_q    <= ST_MP1;
								sda_oe_n_q <= 1'b0;
								cnt_q      <= 7'd0;
							end else begin
								state_q <= ST_WAIT;
								if (addr_ph_q)
									tx_q <= ~dat_q[0];
							end
						end else if (addr_ph_q) begin
							ctl_q[`TW_CTL_ADDR_FLAG] <= 1'b1;
							slave_q    <= 1'b1;
							gc_q       <= gc_match;
							tx_q       <= dat_q[0];
							scl_oe_n_q <= 1'b0;
							state_q    <= ST_WAIT;
						end else if (tx_q && nack_q) begin
							state_q <= ST_IDLE;
							slave_q <= 1'b0;
							tx_q    <= 1'b0;
						end else begin
							scl_oe_n_q <= 1'b0;
							state_q    <= ST_WAIT;
						end
					end
				end
			end
		end
	end
endmodule

module tw_top (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	input  wire [1:0]  scl_i,
	output reg  [1:0]  scl_o,
	output wire [1:0]  scl_oe_n,
	input  wire [1:0]  sda_i,
	output reg  [1:0]  sda_o,
	output wire [1:0]  sda_oe_n
);
	localparam [7:0] IDX_BASE = `TW_IDX_CTL1;
	localparam [7:0] IDX_INST2 = `TW_IDX_CTL2 - `TW_IDX_CTL1;

	reg  [7:0]  wr_idx_q;
	reg         wr_pend_q;
	wire [15:0] ctl_rd;
	wire [15:0] sta_rd;
	wire [15:0] dat_rd;
	wire [15:0] adr_rd;
	wire [7:0]  rd_idx  = haddr[9:2];
	wire        rd_hit  = (haddr[31:10] == 22'd0) && (rd_idx[7:3] == IDX_BASE[7:3]);
	wire        wr_hit  = wr_idx_q[7:3] == IDX_BASE[7:3];
	wire        wr_inst = wr_idx_q[2];
	wire        rd_inst = rd_idx[2];
	reg  [7:0]  rd_byte;

	// Read data is picked in the address phase and held in the data phase.
	always @* begin
		case (rd_idx[1:0])
		`TW_SUB_CTL: rd_byte = rd_inst ? ctl_rd[15:8] : ctl_rd[7:0];
		`TW_SUB_STA: rd_byte = rd_inst ? sta_rd[15:8] : sta_rd[7:0];
		`TW_SUB_DAT: rd_byte = rd_inst ? dat_rd[15:8] : dat_rd[7:0];
		default:     rd_byte = rd_inst ? adr_rd[15:8] : adr_rd[7:0];
		endcase
	end

	// Zero-wait slave; unmapped reads return zero and writes are dropped.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0000_0000;
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 8'h00;
			scl_o     <= 2'b00;
			sda_o     <= 2'b00;
		end else begin
			wr_pend_q <= hsel & hready & htrans[1] & hwrite & (haddr[31:10] == 22'd0);
			if (hsel && hready && htrans[1]) begin
				wr_idx_q <= rd_idx;
				hrdata   <= (!hwrite && rd_hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : inst
			wire sel = wr_pend_q && wr_hit && (wr_inst == IDX_INST2[2] ^ (g == 0));
			tw_engine u_eng (
				.clk        (hclk),
				.rst_n      (hresetn),
				.wr_ctl     (sel && wr_idx_q[1:0] == `TW_SUB_CTL),
				.wr_dat     (sel && wr_idx_q[1:0] == `TW_SUB_DAT),
				.wr_adr     (sel && wr_idx_q[1:0] == `TW_SUB_ADR),
				.wdata      (hwdata[7:0]),
				.ctl_rd     (ctl_rd[g*8 +: 8]),
				.sta_rd     (sta_rd[g*8 +: 8]),
				.dat_rd     (dat_rd[g*8 +: 8]),
				.adr_rd     (adr_rd[g*8 +: 8]),
				.scl_i      (scl_i[g]),
				.sda_i      (sda_i[g]),
				.scl_oe_n_q (scl_oe_n[g]),
				.sda_oe_n_q (sda_oe_n[g])
			);
		end
	endgenerate
endmodule

//--- hw/tw_defs.vh
`ifndef TW_DEFS_VH
`define TW_DEFS_VH

// Register indices; byte address is four times the index.
`define TW_IDX_CTL1      8'hD8
`define TW_IDX_STA1      8'hD9
`define TW_IDX_DAT1      8'hDA
`define TW_IDX_ADR1      8'hDB
`define TW_IDX_CTL2      8'hDC
`define TW_SUB_CTL       2'h0
`define TW_SUB_STA       2'h1
`define TW_SUB_DAT       2'h2
`define TW_SUB_ADR       2'h3

// Control register fields.
`define TW_CTL_RATE_HIGH 7
`define TW_CTL_BUS_ON    6
`define TW_CTL_BEGIN     5
`define TW_CTL_END       4
`define TW_CTL_ADDR_FLAG 3
`define TW_CTL_ACK_EN    2
`define TW_CTL_RATE_MID  1
`define TW_CTL_RATE_LOW  0
`define TW_CTL_RESET     8'h00

// Status register fields.
`define TW_STA_GC        7
`define TW_STA_STOP      6
`define TW_STA_IRQ       5
`define TW_STA_TX        4
`define TW_STA_OCCUPIED  3
`define TW_STA_LOST      2
`define TW_STA_NACK      1
`define TW_STA_TARGET    0

// Reset values of data and own address.
`define TW_DAT_RESET     8'h00
`define TW_ADR_RESET     8'h00

// Oscillator divisors per rate code.
`define TW_DIV_R0        8'd16
`define TW_DIV_R1        8'd14
`define TW_DIV_R2        8'd40
`define TW_DIV_R3        8'd60
`define TW_DIV_R4        8'd120

`endif

//--- testbench/tw_top_sva.sv
`timescale 1ns/1ps
module tw_top_chk (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire [31:0] hrdata,
	input wire        hresp,
	input wire [1:0]  scl_o,
	input wire [1:0]  scl_oe_n,
	input wire [1:0]  sda_o,
	input wire [1:0]  sda_oe_n
);
	reg        wp_q;
	reg [31:0] wa_q;
	reg [1:0]  on_q;
	reg [2:0]  off0_q;
	reg [2:0]  off1_q;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Follow each enable bit from completed control writes, not from the design's own copy.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp_q <= 1'b0;
			wa_q <= 32'h0;
			on_q <= 2'b00;
		end else begin
			wp_q <= hsel && hready && htrans[1] && hwrite;
			wa_q <= haddr;
			on_q[0] <= (wp_q && wa_q == 32'h0000_0360) ? hwdata[6] : on_q[0];
			on_q[1] <= (wp_q && wa_q == 32'h0000_0370) ? hwdata[6] : on_q[1];
		end
	end

	// Cycles spent disabled; a short grace lets the registered enables catch up.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			off0_q <= 3'h0;
			off1_q <= 3'h0;
		end else begin
			off0_q <= on_q[0] ? 3'h0 : off0_q + {2'b00, off0_q != 3'h7};
			off1_q <= on_q[1] ? 3'h0 : off1_q + {2'b00, off1_q != 3'h7};
		end
	end

	property p_ready;
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready)
		else $error("bus answer not ready or not okay");

	property p_upper;
		hrdata[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper)
		else $error("read data upper bits not zero");

	property p_drain;
		scl_o == 2'b00 && sda_o == 2'b00;
	endproperty
	a_drain: assert property (p_drain)
		else $error("line output value not low");

	property p_off0;
		off0_q >= 3'h4 |-> scl_oe_n[0] && sda_oe_n[0];
	endproperty
	a_off0: assert property (p_off0)
		else $error("first controller drives lines while disabled");

	property p_off1;
		off1_q >= 3'h4 |-> scl_oe_n[1] && sda_oe_n[1];
	endproperty
	a_off1: assert property (p_off1)
		else $error("second controller drives lines while disabled");

	property p_low_half;
		$fell(scl_oe_n[0]) |-> !scl_oe_n[0] [*8];
	endproperty
	a_low_half: assert property (p_low_half)
		else $error("clock low half shorter than eight cycles");

	property p_high_half;
		$rose(scl_oe_n[0]) |-> scl_oe_n[0] [*8];
	endproperty
	a_high_half: assert property (p_high_half)
		else $error("clock high half shorter than eight cycles");

	property p_start;
		$fell(sda_oe_n[0]) && scl_oe_n[0] |-> ##[1:64] !scl_oe_n[0];
	endproperty
	a_start: assert property (p_start)
		else $error("no clock low after start");
endmodule

bind tw_top tw_top_chk tw_top_chk_inst (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_o(scl_o),
	.scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
);

//--- testbench/tw_slave_model.sv
`timescale 1ns/1ps
module tw_slave_model #(
	parameter [6:0] ADDR = 7'h2A
) (
	input  wire       scl,
	input  wire       sda,
	output reg        sda_oe_n,
	output reg  [7:0] last_byte
);
	reg [3:0] cnt;
	reg [7:0] sh;
	reg       first;
	reg       acking;

	// Idle until the first start.
	initial begin
		sda_oe_n = 1'b1;
		last_byte = 8'h00;
		sh = 8'h00;
		cnt = 4'h9;
		first = 1'b1;
		acking = 1'b0;
	end

	// Data moving while the clock is high is a start or a stop.
	always @(sda) begin
		if (scl === 1'b1) begin
			cnt = sda ? 4'h9 : 4'h0;
			first = 1'b1;
		end
	end

	// Bits are taken as the clock rises, most significant first.
	always @(posedge scl) begin
		if (cnt < 4'h8) begin
			sh = {sh[6:0], sda};
			cnt = cnt + 4'h1;
		end
	end

	// A foreign address is left unanswered, so the master sees a refusal.
	always @(negedge scl) begin
		if (acking) begin
			sda_oe_n <= 1'b1;
			acking = 1'b0;
			cnt = 4'h0;
			first = 1'b0;
		end else if (cnt == 4'h8) begin
			last_byte = sh;
			cnt = 4'h9;
			if (!first || sh[7:1] == ADDR) begin
				sda_oe_n <= 1'b0;
				acking = 1'b1;
			end
		end
	end
endmodule

//--- testbench/tw_top_tb.sv
`timescale 1ns/1ps
`include "tw_defs.vh"
module tw_top_tb;
	reg         hclk;
	reg         hresetn;
	reg         hsel;
	reg  [31:0] haddr;
	reg  [1:0]  htrans;
	reg         hwrite;
	reg  [2:0]  hsize;
	reg  [31:0] hwdata;
	wire        hreadyout;
	wire [31:0] hrdata;
	wire        hresp;
	wire [1:0]  scl_o;
	wire [1:0]  scl_oe_n;
	wire [1:0]  sda_o;
	wire [1:0]  sda_oe_n;
	wire        tgt_oe_n;
	wire [7:0]  tgt_byte;
	wire [1:0]  scl_ln;
	wire [1:0]  sda_ln;
	reg  [31:0] rd;
	integer     failures;
	integer     num_checks;
	integer     i;

	// Pulled-up lines: low when any party pulls.
	assign scl_ln = scl_oe_n;
	assign sda_ln = sda_oe_n & {1'b1, tgt_oe_n};

	tw_top tw_top_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .scl_i(scl_ln), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
		.sda_i(sda_ln), .sda_o(sda_o), .sda_oe_n(sda_oe_n)
	);

	tw_slave_model tw_slave_model_inst (
		.scl(scl_ln[0]), .sda(sda_ln[0]), .sda_oe_n(tgt_oe_n), .last_byte(tgt_byte)
	);

	// Free-running 50 MHz clock.
	always #10 hclk = ~hclk;

	function [31:0] ra(input [7:0] idx);
		ra = {22'h0, idx, 2'b00};
	endfunction

	task print_verdict;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask

	task chk(input [31:0] g, input [31:0] e);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask

	task hang;
		begin
			failures = failures + 1;
			print_verdict;
		end
	endtask

	// One single transfer; the wait for ready is bounded, never assumed.
	task xfer(input w, input [7:0] idx, input [7:0] d);
		integer n;
		begin
			n = 0;
			hsel <= 1'b1;
			htrans <= 2'b10;
			haddr <= ra(idx);
			hwrite <= w;
			@(posedge hclk);
			while (hreadyout !== 1'b1 && n < 40) begin
				@(posedge hclk);
				n = n + 1;
			end
			hsel <= 1'b0;
			htrans <= 2'b00;
			hwdata <= {24'h0, d};
			@(posedge hclk);
			while (hreadyout !== 1'b1 && n < 40) begin
				@(posedge hclk);
				n = n + 1;
			end
			rd = hrdata;
			if (n >= 40)
				hang;
		end
	endtask

	task rchk(input [7:0] idx, input [31:0] e);
		begin
			xfer(1'b0, idx, 8'h00);
			chk(rd, e);
		end
	endtask

	// Poll a register until one bit reaches the wanted level.
	task wait_on(input [7:0] idx, input integer b, input v);
		integer k;
		begin
			k = 0;
			xfer(1'b0, idx, 8'h00);
			while (rd[b] !== v && k < 400) begin
				xfer(1'b0, idx, 8'h00);
				k = k + 1;
			end
			if (k >= 400)
				hang;
		end
	endtask

	// Main sequence.
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		failures = 0;
		num_checks = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 10; i = i + 1)
			rchk(8'hD7 + i[7:0], 32'h0);
		xfer(1'b1, `TW_IDX_ADR1, 8'hFF);
		rchk(`TW_IDX_ADR1, 32'h0000_00FE);
		xfer(1'b1, `TW_IDX_STA1, 8'hFF);
		rchk(`TW_IDX_STA1, 32'h0);
		xfer(1'b1, 8'hDE, 8'hA5);
		rchk(8'hDE, 32'h0000_00A5);
		rchk(`TW_IDX_DAT1, 32'h0);
		xfer(1'b1, `TW_IDX_CTL2, 8'h84);
		rchk(`TW_IDX_CTL2, 32'h0000_0084);
		chk({28'h0, scl_oe_n, sda_oe_n}, 32'h0000_000F);
		// Master write of address and one byte, both acknowledged.
		xfer(1'b1, `TW_IDX_DAT1, 8'h54);
		xfer(1'b1, `TW_IDX_CTL1, 8'h60);
		wait_on(`TW_IDX_STA1, `TW_STA_IRQ, 1'b1);
		chk(rd, 32'h0000_0030);
		chk({24'h0, tgt_byte}, 32'h0000_0054);
		chk({31'h0, scl_oe_n[0]}, 32'h0);
		xfer(1'b1, `TW_IDX_CTL1, 8'h40);
		xfer(1'b1, `TW_IDX_DAT1, 8'hC3);
		wait_on(`TW_IDX_STA1, `TW_STA_IRQ, 1'b1);
		chk(rd, 32'h0000_0030);
		chk({24'h0, tgt_byte}, 32'h0000_00C3);
		// The end request must clear itself once the stop is on the wire.
		xfer(1'b1, `TW_IDX_CTL1, 8'h50);
		xfer(1'b1, `TW_IDX_DAT1, 8'h00);
		wait_on(`TW_IDX_CTL1, `TW_CTL_END, 1'b0);
		chk(rd, 32'h0000_0040);
		chk({30'h0, scl_oe_n[0], sda_oe_n[0]}, 32'h0000_0003);
		// An unanswered address at a slower rate ends in a stop.
		xfer(1'b1, `TW_IDX_DAT1, 8'h2A);
		xfer(1'b1, `TW_IDX_CTL1, 8'h62);
		wait_on(`TW_IDX_STA1, `TW_STA_IRQ, 1'b1);
		chk(rd & 32'h0000_002F, 32'h0000_0022);
		// The automatic stop takes about two half periods at this rate, so let it finish.
		repeat (120) @(posedge hclk);
		chk({30'h0, scl_oe_n[0], sda_oe_n[0]}, 32'h0000_0003);
		xfer(1'b1, `TW_IDX_DAT1, 8'h00);
		xfer(1'b0, `TW_IDX_STA1, 8'h00);
		chk(rd & 32'h0000_0020, 32'h0);
		xfer(1'b1, `TW_IDX_CTL1, 8'h00);
		repeat (8) @(posedge hclk);
		chk({28'h0, scl_oe_n, sda_oe_n}, 32'h0000_000F);
		print_verdict;
	end
endmodule
